//--- shared/ccu_params.svh
// Register offsets, reset values and timing figures of the compare/capture unit
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

// Register offsets (byte wide, byte addressed)
`define CCU_T2_CTRL      8'h00
`define CCU_T2_LOW       8'h01
`define CCU_T2_HIGH      8'h02
`define CCU_FLAGS        8'h03
`define CCU_CT_CTRL      8'h04
`define CCU_CT_REL_LOW   8'h05
`define CCU_CT_REL_HIGH  8'h06
`define CCU_CH_ENABLE    8'h07
`define CCU_CH_MODE      8'h08
`define CCU_CH_LEVEL     8'h09
`define CCU_CAP_ENABLE   8'h0a
`define CCU_CAP_SW       8'h0b
`define CCU_CH_BASE      8'h0c
`define CCU_CM_ENABLE    8'h16
`define CCU_CM_ASSIGN    8'h17
`define CCU_CM_LEVEL     8'h18
`define CCU_CM_FLAGS     8'h19
`define CCU_CONC_MASK    8'h1a
`define CCU_CONC_VALUE   8'h1b
`define CCU_CM_BASE      8'h20

// Field positions of timer 2 control
`define CCU_T2_RUN_BIT   0
`define CCU_T2_PRE_LSB   1
`define CCU_T2_RLD_EN    3
`define CCU_T2_RLD_MODE  4
`define CCU_T2_EXF_EN    5
// Field positions of compare timer control
`define CCU_CT_RUN_BIT   0
`define CCU_CT_PRE_LSB   1
// Field positions of the flag register
`define CCU_F_TF2        0
`define CCU_F_EXTERNAL_RELOAD_FLAG       1
`define CCU_F_CTF        2
`define CCU_F_CH_LSB     3

// Reset value of every register and the all-ones timer count
`define CCU_RST_BYTE     8'h00
`define CCU_RST_WORD     16'h0000
`define CCU_ALL_ONES     16'hffff

// Oscillator cycles per base tick of each timer
`define CCU_T2_BASE_DIV  12
`define CCU_CT_BASE_DIV  2

`endif

//--- shared/ccu_pkg.sv
// Shared types of the compare/capture unit
package ccu_pkg;
    typedef logic [7:0]  ccu_byte_t;
    typedef logic [15:0] ccu_word_t;
endpackage

//--- src/ccu_cmp_out.sv
// One compare output line with mode 0 and mode 1 behaviour
`timescale 1ns/10ps
`default_nettype none
module ccu_cmp_out (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Events and setup
    input  wire logic en_i,
    input  wire logic mode_i,
    input  wire logic level_i,
    input  wire logic match_i,
    input  wire logic ovf_i,
    // Pin level
    output logic      out_o
);
    logic out_reg;

    assign out_o = out_reg;

    // Match sets or loads, overflow clears in mode 0 only
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_reg <= 1'b0;
        end else if (!en_i) begin
            out_reg <= 1'b0;
        end else if (match_i) begin
            out_reg <= mode_i ? level_i : 1'b1;
        end else if (ovf_i && !mode_i) begin
            out_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- src/ccu_prescale.sv
// Timer prescaler: fixed base divider followed by a selectable power-of-two stage
`timescale 1ns/10ps
`default_nettype none
module ccu_prescale #(
    parameter int BASE_DIV = 12,
    parameter int SEL_W    = 2,
    parameter int PW       = 3
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    // Control
    input  wire logic             run_i,
    input  wire logic [SEL_W-1:0] sel_i,
    // Tick out
    output logic                  tick_o
);
    localparam int BW = $clog2(BASE_DIV + 1);
    localparam logic [BW-1:0] BASE_LAST = BW'(BASE_DIV - 1);

    logic [BW-1:0] base_reg;
    logic [PW-1:0] pre_reg;
    logic [PW-1:0] mask;
    logic          base_tick;

    assign base_tick = run_i && (base_reg == BASE_LAST);
    assign mask      = PW'((1 << sel_i) - 1);
    assign tick_o    = base_tick && ((pre_reg & mask) == mask);

    // Base divider of oscillator cycles
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            base_reg <= '0;
        end else if (!run_i || base_tick) begin
            base_reg <= '0;
        end else begin
            base_reg <= base_reg + BW'(1);
        end
    end

    // Power-of-two stage
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_reg <= '0;
        end else if (!run_i) begin
            pre_reg <= '0;
        end else if (base_tick) begin
            pre_reg <= pre_reg + PW'(1);
        end
    end
endmodule
`default_nettype wire

//--- src/ccu_top.sv
// Compare/capture unit: two timers, thirteen compare and five capture registers
`timescale 1ns/10ps
`default_nettype none
`include "ccu_params.svh"

module ccu_top
    import ccu_pkg::*;
#(
    parameter int N_CH = 5,
    parameter int N_CM = 8
) (
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            rstn_i,
    // Register port
    input  wire logic [7:0]      addr_i,
    input  wire logic [7:0]      wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic      [7:0]      rdata_o,
    // External event pins
    input  wire logic [3:0]      capture_input_i,
    input  wire logic            reload_trigger_pin_i,
    // Compare outputs
    output logic      [N_CH-1:0] ch_out_o,
    output logic      [7:0]      compare_output_p5_o,
    output logic      [N_CM-1:0] cm_out_o,
    // Interrupt requests
    output logic      [6:0]      irq_o
);
    localparam int NT = N_CH + N_CM;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    ccu_byte_t t2_ctrl_reg;
    ccu_byte_t ct_ctrl_reg;
    ccu_word_t t2_reg;
    ccu_word_t ct_reg;
    ccu_word_t ct_rel_reg;
    ccu_word_t ch_reg [N_CH];
    ccu_word_t cm_reg [N_CM];
    ccu_word_t cm_latch_reg [N_CM];
    logic [N_CH-1:0] ch_en_reg;
    logic [N_CH-1:0] ch_mode_reg;
    logic [N_CH-1:0] ch_level_reg;
    logic [N_CH-1:0] cap_en_reg;
    logic [N_CH-1:0] cap_sw_reg;
    logic [N_CM-1:0] cm_en_reg;
    logic [N_CM-1:0] cm_assign_reg;
    logic [N_CM-1:0] cm_level_reg;
    logic [N_CM-1:0] cm_flag_reg;
    ccu_byte_t flag_reg;
    ccu_byte_t conc_mask_reg;
    ccu_byte_t conc_value_reg;
    ccu_byte_t conc_reg;
    ccu_byte_t rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    logic [3:0] cap_edge;
    logic       trig_fall;

    // Two flops before any logic, third for edges
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_reg <= 5'h1f;
            pin_s2_reg <= 5'h1f;
            pin_s3_reg <= 5'h1f;
        end else begin
            pin_s1_reg <= {reload_trigger_pin_i, capture_input_i};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    assign cap_edge  = pin_s2_reg[3:0] & ~pin_s3_reg[3:0];
    assign trig_fall = ~pin_s2_reg[4] & pin_s3_reg[4];

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    logic       wr_t2_lo;
    logic       wr_t2_hi;
    logic [N_CH-1:0] wr_ch_lo;
    logic [N_CH-1:0] wr_ch_hi;
    logic [N_CH-1:0] cap_sw_fire;
    logic [N_CH-1:0] cap_pin_fire;

    assign wr_t2_lo = wr_i && (addr_i == `CCU_T2_LOW);
    assign wr_t2_hi = wr_i && (addr_i == `CCU_T2_HIGH);

    genvar gi;
    generate
        for (gi = 0; gi < N_CH; gi++) begin : g_ch_dec
            assign wr_ch_lo[gi] = wr_i && (addr_i == `CCU_CH_BASE + 8'(2 * gi));
            assign wr_ch_hi[gi] = wr_i && (addr_i == `CCU_CH_BASE + 8'(2 * gi + 1));
            assign cap_sw_fire[gi] = wr_ch_lo[gi] && cap_en_reg[gi] && cap_sw_reg[gi];
            if (gi < 4) begin : g_pin
                assign cap_pin_fire[gi] = cap_edge[gi] && cap_en_reg[gi] && !cap_sw_reg[gi];
            end else begin : g_nopin
                assign cap_pin_fire[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Timer 2
    logic      t2_tick;
    logic      t2_ovf;
    logic      t2_ext_rld;
    ccu_word_t t2_next;
    ccu_word_t crc_value;

    ccu_prescale #(
        .BASE_DIV (`CCU_T2_BASE_DIV),
        .SEL_W    (2),
        .PW       (3)
    ) u_t2_pre (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .run_i     (t2_ctrl_reg[`CCU_T2_RUN_BIT]),
        .sel_i     (t2_ctrl_reg[`CCU_T2_PRE_LSB +: 2]),
        .tick_o    (t2_tick)
    );

    assign crc_value  = ch_reg[0];
    assign t2_ovf     = t2_tick && (t2_reg == `CCU_ALL_ONES);
    assign t2_ext_rld = trig_fall && t2_ctrl_reg[`CCU_T2_RLD_EN]
                        && t2_ctrl_reg[`CCU_T2_RLD_MODE];

    // Next count of timer 2
    always_comb begin
        t2_next = t2_reg;
        if (t2_ext_rld) begin
            t2_next = crc_value;
        end else if (t2_ovf) begin
            t2_next = (t2_ctrl_reg[`CCU_T2_RLD_EN] && !t2_ctrl_reg[`CCU_T2_RLD_MODE])
                      ? crc_value : `CCU_RST_WORD;
        end else if (t2_tick) begin
            t2_next = t2_reg + 16'h0001;
        end
    end

    // Timer 2 count, software write has priority
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t2_reg <= `CCU_RST_WORD;
        end else if (wr_t2_lo) begin
            t2_reg <= {t2_reg[15:8], wdata_i};
        end else if (wr_t2_hi) begin
            t2_reg <= {wdata_i, t2_reg[7:0]};
        end else begin
            t2_reg <= t2_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare timer
    logic ct_tick;
    logic ct_ovf;

    ccu_prescale #(
        .BASE_DIV (`CCU_CT_BASE_DIV),
        .SEL_W    (3),
        .PW       (8)
    ) u_ct_pre (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .run_i     (ct_ctrl_reg[`CCU_CT_RUN_BIT]),
        .sel_i     (ct_ctrl_reg[`CCU_CT_PRE_LSB +: 3]),
        .tick_o    (ct_tick)
    );

    assign ct_ovf = ct_tick && (ct_reg == `CCU_ALL_ONES);

    // Compare timer count with reload at overflow
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ct_reg <= `CCU_RST_WORD;
        end else if (ct_ovf) begin
            ct_reg <= ct_rel_reg;
        end else if (ct_tick) begin
            ct_reg <= ct_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare channels
    logic [NT-1:0] match;
    logic [NT-1:0] ovf;
    logic [NT-1:0] en;
    logic [NT-1:0] mode;
    logic [NT-1:0] level;
    logic [NT-1:0] line;
    ccu_word_t     ct_next;

    assign ct_next = ct_ovf ? ct_rel_reg : ct_reg + 16'h0001;

    generate
        for (gi = 0; gi < NT; gi++) begin : g_cmp
            if (gi < N_CH) begin : g_t2
                // Channel registers run against timer 2 only
                assign match[gi] = t2_tick && (t2_next == ch_reg[gi]) && !cap_en_reg[gi];
                assign ovf[gi]   = t2_ovf;
                assign en[gi]    = ch_en_reg[gi] && !cap_en_reg[gi];
                assign mode[gi]  = ch_mode_reg[gi];
                assign level[gi] = ch_level_reg[gi];
            end else begin : g_cm
                localparam int K = gi - N_CH;
                // Compare timer side uses latch copy, timer 2 side the register
                assign match[gi] = cm_assign_reg[K]
                                   ? (ct_tick && (ct_next == cm_latch_reg[K]))
                                   : (t2_tick && (t2_next == cm_reg[K]));
                assign ovf[gi]   = cm_assign_reg[K] ? ct_ovf : t2_ovf;
                assign en[gi]    = cm_en_reg[K];
                assign mode[gi]  = !cm_assign_reg[K];
                assign level[gi] = cm_level_reg[K];
            end
            ccu_cmp_out u_out (
                .ref_clk_i (ref_clk_i),
                .rstn_i    (rstn_i),
                .en_i      (en[gi]),
                .mode_i    (mode[gi]),
                .level_i   (level[gi]),
                .match_i   (match[gi]),
                .ovf_i     (ovf[gi]),
                .out_o     (line[gi])
            );
        end
    endgenerate

    assign ch_out_o            = line[N_CH-1:0];
    assign cm_out_o            = line[NT-1:N_CH];
    assign compare_output_p5_o = conc_reg;

    // Concurrent outputs loaded on a mode 1 match of the last channel
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            conc_reg <= `CCU_RST_BYTE;
        end else if (match[N_CH-1] && en[N_CH-1] && mode[N_CH-1]) begin
            conc_reg <= (conc_reg & ~conc_mask_reg) | (conc_value_reg & conc_mask_reg);
        end
    end

    // Latch copies reloaded at every compare timer overflow
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int k = 0; k < N_CM; k++) begin
                cm_latch_reg[k] <= `CCU_RST_WORD;
            end
        end else if (ct_ovf) begin
            for (int k = 0; k < N_CM; k++) begin
                cm_latch_reg[k] <= cm_reg[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel registers: software write or capture of timer 2
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int k = 0; k < N_CH; k++) begin
                ch_reg[k] <= `CCU_RST_WORD;
            end
        end else begin
            for (int k = 0; k < N_CH; k++) begin
                if (cap_sw_fire[k] || cap_pin_fire[k]) begin
                    ch_reg[k] <= t2_reg;
                end else if (wr_ch_lo[k]) begin
                    ch_reg[k] <= {ch_reg[k][15:8], wdata_i};
                end else if (wr_ch_hi[k]) begin
                    ch_reg[k] <= {wdata_i, ch_reg[k][7:0]};
                end
            end
        end
    end

    // General compare registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int k = 0; k < N_CM; k++) begin
                cm_reg[k] <= `CCU_RST_WORD;
            end
        end else if (wr_i && (addr_i >= `CCU_CM_BASE)
                     && (addr_i < `CCU_CM_BASE + 8'(2 * N_CM))) begin
            for (int k = 0; k < N_CM; k++) begin
                if (addr_i == `CCU_CM_BASE + 8'(2 * k)) begin
                    cm_reg[k] <= {cm_reg[k][15:8], wdata_i};
                end
                if (addr_i == `CCU_CM_BASE + 8'(2 * k + 1)) begin
                    cm_reg[k] <= {wdata_i, cm_reg[k][7:0]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t2_ctrl_reg    <= `CCU_RST_BYTE;
            ct_ctrl_reg    <= `CCU_RST_BYTE;
            ct_rel_reg     <= `CCU_RST_WORD;
            ch_en_reg      <= '0;
            ch_mode_reg    <= '0;
            ch_level_reg   <= '0;
            cap_en_reg     <= '0;
            cap_sw_reg     <= '0;
            cm_en_reg      <= '0;
            cm_assign_reg  <= '0;
            cm_level_reg   <= '0;
            conc_mask_reg  <= `CCU_RST_BYTE;
            conc_value_reg <= `CCU_RST_BYTE;
        end else if (wr_i) begin
            unique case (addr_i)
                `CCU_T2_CTRL:     t2_ctrl_reg    <= wdata_i;
                `CCU_CT_CTRL:     ct_ctrl_reg    <= wdata_i;
                `CCU_CT_REL_LOW:  ct_rel_reg     <= {ct_rel_reg[15:8], wdata_i};
                `CCU_CT_REL_HIGH: ct_rel_reg     <= {wdata_i, ct_rel_reg[7:0]};
                `CCU_CH_ENABLE:   ch_en_reg      <= wdata_i[N_CH-1:0];
                `CCU_CH_MODE:     ch_mode_reg    <= wdata_i[N_CH-1:0];
                `CCU_CH_LEVEL:    ch_level_reg   <= wdata_i[N_CH-1:0];
                `CCU_CAP_ENABLE:  cap_en_reg     <= wdata_i[N_CH-1:0];
                `CCU_CAP_SW:      cap_sw_reg     <= wdata_i[N_CH-1:0];
                `CCU_CM_ENABLE:   cm_en_reg      <= wdata_i[N_CM-1:0];
                `CCU_CM_ASSIGN:   cm_assign_reg  <= wdata_i[N_CM-1:0];
                `CCU_CM_LEVEL:    cm_level_reg   <= wdata_i[N_CM-1:0];
                `CCU_CONC_MASK:   conc_mask_reg  <= wdata_i;
                `CCU_CONC_VALUE:  conc_value_reg <= wdata_i;
                default:          ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags, write one to clear, a new event wins over the clear
    logic [7:0]      flag_set;
    logic [7:0]      flag_clr;
    logic [N_CM-1:0] cm_set;
    logic [N_CM-1:0] cm_clr;

    assign flag_set[`CCU_F_TF2]  = t2_ovf;
    assign flag_set[`CCU_F_EXTERNAL_RELOAD_FLAG] = trig_fall && t2_ctrl_reg[`CCU_T2_RLD_MODE];
    assign flag_set[`CCU_F_CTF]  = ct_ovf;
    assign flag_set[7:`CCU_F_CH_LSB] = (match[N_CH-1:0] & en[N_CH-1:0])
                                       | cap_sw_fire | cap_pin_fire;
    assign flag_clr = (wr_i && (addr_i == `CCU_FLAGS)) ? wdata_i : 8'h00;
    assign cm_set   = match[NT-1:N_CH] & cm_en_reg;
    assign cm_clr   = (wr_i && (addr_i == `CCU_CM_FLAGS)) ? wdata_i[N_CM-1:0] : '0;

    // Sticky flags
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_reg    <= `CCU_RST_BYTE;
            cm_flag_reg <= '0;
        end else begin
            flag_reg    <= flag_set | (flag_reg & ~flag_clr);
            cm_flag_reg <= cm_set | (cm_flag_reg & ~cm_clr);
        end
    end

    // Seven requests
    assign irq_o[0] = flag_reg[`CCU_F_TF2]
                      | (flag_reg[`CCU_F_EXTERNAL_RELOAD_FLAG] & t2_ctrl_reg[`CCU_T2_EXF_EN]);
    assign irq_o[1] = flag_reg[`CCU_F_CTF];
    assign irq_o[5:2] = flag_reg[`CCU_F_CH_LSB +: 4];
    assign irq_o[6] = flag_reg[7] | (|cm_flag_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data valid only in the cycle after the strobe
    ccu_byte_t rd_mux;

    always_comb begin
        rd_mux = `CCU_RST_BYTE;
        unique case (addr_i)
            `CCU_T2_CTRL:     rd_mux = t2_ctrl_reg;
            `CCU_T2_LOW:      rd_mux = t2_reg[7:0];
            `CCU_T2_HIGH:     rd_mux = t2_reg[15:8];
            `CCU_FLAGS:       rd_mux = flag_reg;
            `CCU_CT_CTRL:     rd_mux = ct_ctrl_reg;
            `CCU_CT_REL_LOW:  rd_mux = ct_rel_reg[7:0];
            `CCU_CT_REL_HIGH: rd_mux = ct_rel_reg[15:8];
            `CCU_CH_ENABLE:   rd_mux = 8'(ch_en_reg);
            `CCU_CH_MODE:     rd_mux = 8'(ch_mode_reg);
            `CCU_CH_LEVEL:    rd_mux = 8'(ch_level_reg);
            `CCU_CAP_ENABLE:  rd_mux = 8'(cap_en_reg);
            `CCU_CAP_SW:      rd_mux = 8'(cap_sw_reg);
            `CCU_CM_ENABLE:   rd_mux = 8'(cm_en_reg);
            `CCU_CM_ASSIGN:   rd_mux = 8'(cm_assign_reg);
            `CCU_CM_LEVEL:    rd_mux = 8'(cm_level_reg);
            `CCU_CM_FLAGS:    rd_mux = 8'(cm_flag_reg);
            `CCU_CONC_MASK:   rd_mux = conc_mask_reg;
            `CCU_CONC_VALUE:  rd_mux = conc_value_reg;
            default: begin
                for (int k = 0; k < N_CH; k++) begin
                    if (addr_i == `CCU_CH_BASE + 8'(2 * k)) rd_mux = ch_reg[k][7:0];
                    if (addr_i == `CCU_CH_BASE + 8'(2 * k + 1)) rd_mux = ch_reg[k][15:8];
                end
                for (int k = 0; k < N_CM; k++) begin
                    if (addr_i == `CCU_CM_BASE + 8'(2 * k)) rd_mux = cm_reg[k][7:0];
                    if (addr_i == `CCU_CM_BASE + 8'(2 * k + 1)) rd_mux = cm_reg[k][15:8];
                end
            end
        endcase
    end

    // Registered read data
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= `CCU_RST_BYTE;
        end else begin
            rdata_reg <= rd_i ? rd_mux : `CCU_RST_BYTE;
        end
    end

    assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

//--- tb/ccu_pins.sv
// Model of the external capture and reload trigger pins
`timescale 1ns/10ps
`default_nettype none
module ccu_pins (
    input  wire logic       ref_clk_i,
    input  wire logic [4:0] req_i,
    output logic      [3:0] capture_o,
    output logic            trigger_o
);
    logic [2:0] cnt [5] = '{default: 3'h0};
    // Each request gives a six cycle pulse
    always @(posedge ref_clk_i)
        for (int i = 0; i < 5; i++)
            cnt[i] <= req_i[i] ? 3'h6 : cnt[i] - 3'(cnt[i] != 3'h0);
    // Capture pins rest low, trigger rests high
    always_comb begin
        for (int i = 0; i < 4; i++) capture_o[i] = cnt[i] != 3'h0;
        trigger_o = cnt[4] == 3'h0;
    end
endmodule
`default_nettype wire

//--- tb/ccu_props.sv
// Port checker of the compare/capture unit
`timescale 1ns/10ps
`default_nettype none
module ccu_props #(parameter int N_CH = 5, parameter int N_CM = 8) (
    input wire logic            ref_clk_i, rstn_i, wr_i, rd_i,
    input wire logic [7:0]      addr_i, wdata_i, rdata_o, compare_output_p5_o,
    input wire logic [N_CH-1:0] ch_out_o,
    input wire logic [N_CM-1:0] cm_out_o,
    input wire logic [6:0]      irq_o
);
    logic ch_c, cm_c, cc_c, t2_c, ct_c;
    // Setup written since reset
    always_ff @(posedge ref_clk_i or negedge rstn_i)
        if (!rstn_i) {ch_c, cm_c, cc_c, t2_c, ct_c} <= 5'h00;
        else if (wr_i) begin
            ch_c <= ch_c | (addr_i inside {8'h07, 8'h0a});
            cm_c <= cm_c | (addr_i == 8'h16);
            cc_c <= cc_c | (addr_i == 8'h1a);
            t2_c <= t2_c | (addr_i == 8'h00 && (wdata_i[0] || wdata_i[5]));
            ct_c <= ct_c | (addr_i == 8'h04 && wdata_i[0]);
        end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rst; !$past(rstn_i) |->
        {ch_out_o, cm_out_o, compare_output_p5_o, irq_o} == '0; endproperty
    a_rst: assert property (p_rst) else $error("outputs set at reset exit");
    property p_ch; !ch_c |-> ch_out_o == '0; endproperty
    a_ch: assert property (p_ch) else $error("channel line unconfigured");
    property p_cm; !cm_c |-> cm_out_o == '0; endproperty
    a_cm: assert property (p_cm) else $error("general line unconfigured");
    property p_cc; !cc_c |-> compare_output_p5_o == 8'h00; endproperty
    a_cc: assert property (p_cc) else $error("port five line unconfigured");
    property p_t2; !t2_c |-> !irq_o[0]; endproperty
    a_t2: assert property (p_t2) else $error("timer 2 request early");
    property p_ct; !ct_c |-> !irq_o[1]; endproperty
    a_ct: assert property (p_ct) else $error("compare timer request early");
    property p_chf; !ch_c |-> irq_o[5:2] == 4'h0 && !(irq_o[6] && !cm_c); endproperty
    a_chf: assert property (p_chf) else $error("channel request early");
    property p_rd; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data outside its cycle");
    c_ch: cover property ($rose(ch_out_o[2]));
    c_cm: cover property ($rose(cm_out_o[0]));
    c_irq: cover property ($rose(irq_o[0]));
endmodule
bind ccu_top ccu_props #(.N_CH(N_CH), .N_CM(N_CM)) u_props (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .compare_output_p5_o(compare_output_p5_o), .ch_out_o(ch_out_o),
    .cm_out_o(cm_out_o), .irq_o(irq_o));
`default_nettype wire

//--- tb/compare_capture_unit_tb_top.sv
// Self-checking bench of the compare/capture unit
`timescale 1ns/10ps
`default_nettype none
module compare_capture_unit_tb_top;
    logic ref_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, trig;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, p5, d, cm_out;
    logic [4:0] ch_out, req = 5'h00;
    logic [6:0] irq;
    logic [3:0] cap;
    logic [15:0] cfg [$];
    wire logic [19:0] mon = {irq, cm_out, ch_out};
    int miscompares = 0, checks_done = 0, cyc = 0, n;
    always #2 ref_clk_i = ~ref_clk_i;
    ccu_top u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_i(cap),
        .reload_trigger_pin_i(trig), .ch_out_o(ch_out), .compare_output_p5_o(p5),
        .cm_out_o(cm_out), .irq_o(irq));
    ccu_pins u_pins (.ref_clk_i(ref_clk_i), .req_i(req), .capture_o(cap), .trigger_o(trig));
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            close_out;
        end
    end
    task wr(input logic [15:0] av);
        @(posedge ref_clk_i) {addr_i, wdata_i, wr_i} <= {av, 1'b1};
        @(posedge ref_clk_i) wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk_i) {addr_i, rd_i} <= {a, 1'b1};
        @(posedge ref_clk_i) rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task wt(input int i, input logic v);
        for (n = 0; n < 400 && mon[i] !== v; n++) @(posedge ref_clk_i);
        #1;
    endtask
    task pulse(input logic [4:0] m);
        @(posedge ref_clk_i) req <= m;
        @(posedge ref_clk_i) req <= 5'h00;
        repeat (8) @(posedge ref_clk_i);
    endtask
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rd(8'h02);
        chk("t2 hi", 8'h00, d);
        rd(8'h3f);
        chk("unmapped", 8'h00, d);
        $display("test reset done");
        // Auto reload from fff0, ch1 mode 1 at fff2, ch2 mode 0 at fff4
        cfg = '{16'h01f0, 16'h02ff, 16'h0cf0, 16'h0dff, 16'h0ef2, 16'h0fff, 16'h10f4,
                16'h11ff, 16'h0706, 16'h0802, 16'h0902, 16'h0009};
        foreach (cfg[i]) wr(cfg[i]);
        wt(2, 1'b1);
        chk("ch2 rise", 8'h01, {7'h0, ch_out[2]});
        wt(2, 1'b0);
        chk("ch2 fall", 8'h00, {7'h0, ch_out[2]});
        chk("ch1 level", 8'h01, {7'h0, ch_out[1]});
        chk("flags", 8'h07, {5'h0, irq[4:3], irq[0]});
        rd(8'h02);
        chk("reloaded hi", 8'hff, d);
        $display("test compare done");
        wr(16'h0a08);
        pulse(5'h08);
        rd(8'h13);
        chk("pin capture", 8'hff, d);
        cfg = '{16'h0a18, 16'h0b10, 16'h1400};
        foreach (cfg[i]) wr(cfg[i]);
        rd(8'h15);
        chk("write capture", 8'hff, d);
        $display("test capture done");
        // Pin reload to 1234, cm0 on timer 2 at 1240
        cfg = '{16'h0c34, 16'h0d12, 16'h2040, 16'h2112, 16'h1601, 16'h1700, 16'h1801,
                16'h0039, 16'h03ff};
        foreach (cfg[i]) wr(cfg[i]);
        pulse(5'h10);
        chk("pin request", 8'h01, {7'h0, irq[0]});
        rd(8'h02);
        chk("pin reload hi", 8'h12, d);
        wt(5, 1'b1);
        chk("cm0 line", 8'h01, {7'h0, cm_out[0]});
        $display("test reload done");
        close_out;
    end
endmodule
`default_nettype wire
